/* design/dtm_channel.sv */
// DMA channel engine: control structures, transfer-mode sequencer, FIFO.
// Assumes requests and source data come from logic on sys_clk.
`timescale 1ns/1ns

module dtm_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = count_reg != '0;
  assign out_data = mem[rd_ptr_reg];
  assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      // Registered so the source sees ready straight from a flop
      in_ready <= count_next != FULL;
    end
  end
endmodule : dtm_fifo

module dtm_channel (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic chan_en,
  input wire logic dma_req,
  input wire logic ctl_wr,
  input wire logic [1:0] ctl_sel,
  input wire logic [dtm_pkg::TASK_IW-1:0] ctl_idx,
  input wire dtm_pkg::dtm_ctl_t ctl_data,
  input wire logic src_valid,
  input wire logic [dtm_pkg::DATA_W-1:0] src_data,
  output logic src_ready,
  output logic dst_valid_reg,
  output logic [dtm_pkg::DATA_W-1:0] dst_data_reg,
  input wire logic dst_ready,
  output logic busy_reg,
  output logic use_alt_reg,
  output logic [dtm_pkg::COUNT_W-1:0] items_left_reg,
  output logic done_reg
);
  dtm_pkg::dtm_state_t state_reg;
  dtm_pkg::dtm_ctl_t prim_reg;
  dtm_pkg::dtm_ctl_t alt_reg;
  dtm_pkg::dtm_ctl_t task_mem [dtm_pkg::TASK_N];
  dtm_pkg::dtm_ctl_t cur_ctl;
  dtm_pkg::dtm_ctl_t task_cur;
  logic run_auto_reg;
  logic sg_active_reg;
  logic [dtm_pkg::TASK_IW-1:0] sg_idx_reg;
  logic credit_reg;
  logic fifo_valid;
  logic [dtm_pkg::DATA_W-1:0] fifo_data;
  logic slot_free;
  logic move;
  logic complete;
  logic pick_consume;
  logic wb_prim;
  logic wb_alt;
  logic sg_copy;
  logic sg_bad;
  logic [2:0] pick_mode;

  dtm_fifo #(.W(dtm_pkg::DATA_W), .DEPTH(dtm_pkg::FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .in_valid(src_valid),
    .in_data(src_data),
    .in_ready(src_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(move)
  );

  assign cur_ctl = use_alt_reg ? alt_reg : prim_reg;
  assign task_cur = task_mem[sg_idx_reg];
  assign pick_mode = cur_ctl.transfer_mode_field;
  assign slot_free = !dst_valid_reg || dst_ready;
  // Items move only while running; gated ones need a held request
  assign move = (state_reg == dtm_pkg::DTM_RUN) && fifo_valid && slot_free
      && (run_auto_reg || credit_reg);
  assign complete = move && (items_left_reg == dtm_pkg::COUNT_LAST);
  // A peripheral list refused in the alternate slot drops its request,
  // otherwise the channel would spin between idle and pick for ever
  assign pick_consume = (state_reg == dtm_pkg::DTM_PICK)
      && (pick_mode != dtm_pkg::MODE_BASIC)
      && (pick_mode != dtm_pkg::MODE_PING)
      && !(pick_mode == dtm_pkg::MODE_PER_SG && !use_alt_reg);
  assign sg_bad = (task_cur.transfer_mode_field != dtm_pkg::MODE_ALT_MEM_SG)
      && (task_cur.transfer_mode_field != dtm_pkg::MODE_ALT_PER_SG);
  assign sg_copy = state_reg == dtm_pkg::DTM_SG_LOAD;
  // A finished structure is parked at stop, so ping-pong only returns
  // to it once the host has written it again
  assign wb_prim = (complete && !use_alt_reg)
      || (sg_copy && sg_bad)
      || (complete && sg_active_reg
          && sg_idx_reg == prim_reg.item_count_minus_one[2:0]);
  assign wb_alt = complete && use_alt_reg;

  // Request latch: a request in the consuming cycle is kept
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      credit_reg <= 1'b0;
    end else begin
      credit_reg <= dma_req
          || (credit_reg && !(move && !run_auto_reg) && !pick_consume);
    end
  end

  // Hardware write-back takes priority over a host write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prim_reg <= dtm_pkg::CTL_RESET;
    end else if (wb_prim) begin
      prim_reg.transfer_mode_field <= dtm_pkg::MODE_STOP;
    end else if (ctl_wr && ctl_sel == dtm_pkg::SEL_PRIMARY) begin
      prim_reg <= ctl_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      alt_reg <= dtm_pkg::CTL_RESET;
    end else if (sg_copy) begin
      alt_reg <= task_cur;
    end else if (wb_alt) begin
      alt_reg.transfer_mode_field <= dtm_pkg::MODE_STOP;
    end else if (ctl_wr && ctl_sel == dtm_pkg::SEL_ALTERNATE) begin
      alt_reg <= ctl_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (ctl_wr && ctl_sel == dtm_pkg::SEL_TASK) begin
      task_mem[ctl_idx] <= ctl_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= dtm_pkg::DTM_IDLE;
      use_alt_reg <= 1'b0;
      run_auto_reg <= 1'b0;
      sg_active_reg <= 1'b0;
      sg_idx_reg <= '0;
      items_left_reg <= '0;
    end else begin
      case (state_reg)
        dtm_pkg::DTM_IDLE: begin
          if (chan_en && credit_reg) begin
            state_reg <= dtm_pkg::DTM_PICK;
          end
        end
        dtm_pkg::DTM_PICK: begin
          items_left_reg <= cur_ctl.item_count_minus_one;
          case (pick_mode)
            dtm_pkg::MODE_BASIC, dtm_pkg::MODE_PING: begin
              run_auto_reg <= 1'b0;
              state_reg <= dtm_pkg::DTM_RUN;
            end
            dtm_pkg::MODE_AUTO: begin
              run_auto_reg <= 1'b1;
              state_reg <= dtm_pkg::DTM_RUN;
            end
            dtm_pkg::MODE_MEM_SG, dtm_pkg::MODE_PER_SG: begin
              if (!use_alt_reg) begin
                sg_active_reg <= 1'b1;
                sg_idx_reg <= '0;
                state_reg <= dtm_pkg::DTM_SG_LOAD;
              end else begin
                state_reg <= dtm_pkg::DTM_IDLE;
              end
            end
            default: begin
              state_reg <= dtm_pkg::DTM_IDLE;
            end
          endcase
        end
        dtm_pkg::DTM_SG_LOAD: begin
          use_alt_reg <= 1'b1;
          items_left_reg <= task_cur.item_count_minus_one;
          run_auto_reg <= task_cur.transfer_mode_field
              == dtm_pkg::MODE_ALT_MEM_SG;
          if (sg_bad) begin
            // A task entry with a non-alternate code ends the list
            sg_active_reg <= 1'b0;
            use_alt_reg <= 1'b0;
            state_reg <= dtm_pkg::DTM_IDLE;
          end else begin
            state_reg <= dtm_pkg::DTM_RUN;
          end
        end
        dtm_pkg::DTM_RUN: begin
          if (move) begin
            items_left_reg <= items_left_reg - 1'b1;
          end
          if (complete) begin
            if (sg_active_reg) begin
              if (sg_idx_reg == prim_reg.item_count_minus_one[2:0]) begin
                sg_active_reg <= 1'b0;
                use_alt_reg <= 1'b0;
                state_reg <= dtm_pkg::DTM_IDLE;
              end else begin
                sg_idx_reg <= sg_idx_reg + 1'b1;
                state_reg <= dtm_pkg::DTM_SG_LOAD;
              end
            end else if (pick_mode == dtm_pkg::MODE_PING) begin
              use_alt_reg <= !use_alt_reg;
              state_reg <= dtm_pkg::DTM_PICK;
            end else begin
              state_reg <= dtm_pkg::DTM_IDLE;
            end
          end
        end
        default: begin
          state_reg <= dtm_pkg::DTM_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dst_valid_reg <= 1'b0;
      dst_data_reg <= '0;
    end else if (slot_free) begin
      dst_valid_reg <= move;
      if (move) begin
        dst_data_reg <= fifo_data;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      done_reg <= complete;
      busy_reg <= state_reg != dtm_pkg::DTM_IDLE;
    end
  end

  // Helper counters for the checks below
  logic [10:0] moved_cnt;
  logic [9:0] loaded_cnt;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      moved_cnt <= '0;
      loaded_cnt <= '0;
    end else if (state_reg != dtm_pkg::DTM_RUN) begin
      // Configured count of the structure about to run
      moved_cnt <= '0;
      loaded_cnt <= sg_copy ? task_cur.item_count_minus_one
          : cur_ctl.item_count_minus_one;
    end else if (move) begin
      moved_cnt <= moved_cnt + 11'h001;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_stop_no_run: assert property (
    state_reg == dtm_pkg::DTM_PICK && pick_mode == dtm_pkg::MODE_STOP
    |=> state_reg == dtm_pkg::DTM_IDLE ##1 !move)
    else $error("stop mode entered a run");
  a_basic_needs_req: assert property (
    move && !run_auto_reg |-> credit_reg)
    else $error("gated item moved without a request");
  a_auto_no_stall: assert property (
    state_reg == dtm_pkg::DTM_RUN && run_auto_reg && fifo_valid && slot_free
    |-> move)
    else $error("auto-request run stalled");
  a_ping_swap: assert property (
    complete && !sg_active_reg && pick_mode == dtm_pkg::MODE_PING
    |=> use_alt_reg != $past(use_alt_reg) && state_reg == dtm_pkg::DTM_PICK)
    else $error("ping-pong did not swap structure");
  a_plain_ends: assert property (
    complete && !sg_active_reg && (pick_mode == dtm_pkg::MODE_BASIC
        || pick_mode == dtm_pkg::MODE_AUTO)
    |=> state_reg == dtm_pkg::DTM_IDLE && done_reg)
    else $error("basic or auto cycle did not end");
  a_count_load: assert property (
    state_reg == dtm_pkg::DTM_PICK && pick_mode == dtm_pkg::MODE_AUTO
    |=> items_left_reg == $past(cur_ctl.item_count_minus_one))
    else $error("item count not loaded");
  a_item_total: assert property (
    complete |-> moved_cnt == {1'b0, loaded_cnt})
    else $error("wrong number of items in cycle");
  a_sg_copy: assert property (
    sg_copy && !sg_bad |=> alt_reg == $past(task_cur) && use_alt_reg
    ##1 state_reg == dtm_pkg::DTM_RUN || state_reg == dtm_pkg::DTM_IDLE
        || state_reg == dtm_pkg::DTM_SG_LOAD)
    else $error("task entry not copied");

  c_auto_done: cover property (run_auto_reg && complete);
  c_ping_swap: cover property (complete && pick_mode == dtm_pkg::MODE_PING);
  c_sg_next: cover property (sg_active_reg && complete ##1 sg_copy);
  c_fifo_full: cover property (!src_ready && src_valid);
endmodule : dtm_channel

/* inc/dtm_pkg.sv */
// Constants and types for the DMA channel transfer-mode engine.
// Assumes a single clock domain and a host that writes control words.
package dtm_pkg;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int COUNT_W = 10;
  localparam int TASK_N = 8;
  localparam int TASK_IW = 3;
  localparam int MODE_W = 3;

  // Transfer-mode codes
  localparam logic [2:0] MODE_STOP = 3'h0;
  localparam logic [2:0] MODE_BASIC = 3'h1;
  localparam logic [2:0] MODE_AUTO = 3'h2;
  localparam logic [2:0] MODE_PING = 3'h3;
  localparam logic [2:0] MODE_MEM_SG = 3'h4;
  localparam logic [2:0] MODE_ALT_MEM_SG = 3'h5;
  localparam logic [2:0] MODE_PER_SG = 3'h6;
  localparam logic [2:0] MODE_ALT_PER_SG = 3'h7;

  // Control-word write targets
  localparam logic [1:0] SEL_PRIMARY = 2'h0;
  localparam logic [1:0] SEL_ALTERNATE = 2'h1;
  localparam logic [1:0] SEL_TASK = 2'h2;

  localparam logic [9:0] COUNT_LAST = 10'h000;

  typedef struct packed {
    logic [COUNT_W-1:0] item_count_minus_one;
    logic [MODE_W-1:0] transfer_mode_field;
  } dtm_ctl_t;

  localparam dtm_ctl_t CTL_RESET = '{10'h000, 3'h0};

  typedef enum logic [1:0] {
    DTM_IDLE,
    DTM_PICK,
    DTM_SG_LOAD,
    DTM_RUN
  } dtm_state_t;
endpackage : dtm_pkg

/* tb/dtm_far_model.sv */
// Far-side model: a data source feeding the channel FIFO and a data sink.
// Assumes the bench raises feed_num to release more counting words.
`timescale 1ns/1ns

module dtm_far_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [31:0] feed_num,
  input wire logic stall_en,
  input wire logic src_ready,
  output logic src_valid,
  output logic [31:0] src_data,
  input wire logic dst_valid_reg,
  input wire logic [31:0] dst_data_reg,
  output logic dst_ready,
  output int rx_count,
  output logic [31:0] rx_last,
  output int rx_bad
);
  int seq;
  logic [31:0] dat;
  logic ph;
  logic acc;
  logic take;

  initial begin
    seq = 0;
    ph = 1'b0;
    rx_count = 0;
    rx_bad = 0;
    rx_last = 32'h0000_0000;
    src_valid = 1'b0;
    src_data = 32'h0000_0000;
    dst_ready = 1'b1;
  end

  // Samples at the edge and answers 1 ns later, like the bench drivers
  always @(posedge sys_clk) begin
    acc = src_valid && src_ready && rst_b;
    take = dst_valid_reg && dst_ready && rst_b;
    // The word is taken at the edge; it may already change 1 ns later
    dat = dst_data_reg;
    #1;
    if (take) begin
      // Words must leave in the order the counting source sent them
      if (dat !== 32'(rx_count)) begin
        rx_bad++;
      end
      rx_count++;
      rx_last = dat;
    end
    if (acc) begin
      seq++;
    end
    src_valid = (seq < feed_num);
    // An idle data line toggles each cycle, so it is not held at the last word
    src_data = src_valid ? 32'(seq) : ~src_data;
    dst_ready = stall_en ? ph : 1'b1;
    ph = !ph;
  end
endmodule : dtm_far_model

/* tb/tb_top.sv */
// Self-checking bench for the DMA channel transfer-mode engine.
// Assumes one sys_clk domain and the far-side model in dtm_far_model.
`timescale 1ns/1ns

module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic chan_en = 1'b0;
  logic dma_req = 1'b0;
  logic ctl_wr = 1'b0;
  logic [1:0] ctl_sel = 2'h0;
  logic [2:0] ctl_idx = 3'h0;
  dtm_pkg::dtm_ctl_t ctl_data = dtm_pkg::CTL_RESET;
  logic src_valid, src_ready, dst_valid_reg, dst_ready;
  logic [31:0] src_data, dst_data_reg, rx_last;
  logic busy_reg, use_alt_reg, done_reg;
  logic [9:0] items_left_reg;
  logic stall_en = 1'b0;
  int feed_num = 0;
  int rx_count, done_cnt = 0;
  int rx_bad;
  int num_errors = 0;
  int check_count = 0;

  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  dtm_channel dut (.sys_clk(sys_clk), .rst_b(rst_b), .chan_en(chan_en),
    .dma_req(dma_req), .ctl_wr(ctl_wr), .ctl_sel(ctl_sel),
    .ctl_idx(ctl_idx), .ctl_data(ctl_data), .src_valid(src_valid),
    .src_data(src_data), .src_ready(src_ready),
    .dst_valid_reg(dst_valid_reg), .dst_data_reg(dst_data_reg),
    .dst_ready(dst_ready), .busy_reg(busy_reg), .use_alt_reg(use_alt_reg),
    .items_left_reg(items_left_reg), .done_reg(done_reg));

  dtm_far_model far (.sys_clk(sys_clk), .rst_b(rst_b), .feed_num(feed_num),
    .stall_en(stall_en), .src_ready(src_ready), .src_valid(src_valid),
    .src_data(src_data), .dst_valid_reg(dst_valid_reg),
    .dst_data_reg(dst_data_reg), .dst_ready(dst_ready),
    .rx_count(rx_count), .rx_last(rx_last), .rx_bad(rx_bad));

  always @(posedge sys_clk) begin
    if (done_reg === 1'b1) begin
      done_cnt++;
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [1:0] sel, input logic [2:0] idx,
                    input logic [2:0] mode, input logic [9:0] cnt);
    @(posedge sys_clk);
    #1 ctl_wr = 1'b1;
    ctl_sel = sel;
    ctl_idx = idx;
    ctl_data = '{cnt, mode};
    @(posedge sys_clk);
    #1 ctl_wr = 1'b0;
  endtask : wr

  task automatic req;
    @(posedge sys_clk);
    #1 dma_req = 1'b1;
    @(posedge sys_clk);
    #1 dma_req = 1'b0;
  endtask : req

  // Bounded wait for the sink to hold n items in total
  task automatic wait_items(input int n);
    int i;
    for (i = 0; i < 6000 && rx_count < n; i++) begin
      @(posedge sys_clk);
    end
    if (rx_count < n) begin
      $display("[FAIL] t=%0t got %h exp %h", $time, rx_count, n);
      num_errors++;
      tally_and_finish();
    end
  endtask : wait_items

  // Nothing more may arrive while the channel has no right to move
  task automatic quiet(input int n);
    repeat (20) @(posedge sys_clk);
    chk(32'(rx_count), 32'(n));
  endtask : quiet

  task automatic fill_and_stop;
    feed_num = 32;
    repeat (45) @(posedge sys_clk);
    chk({31'h0, src_ready}, 32'h0);
    wr(dtm_pkg::SEL_PRIMARY, 3'h0, dtm_pkg::MODE_STOP, 10'h000);
    chan_en = 1'b1;
    req();
    quiet(0);
  endtask : fill_and_stop

  // Full-size count with a stalling sink; also drains the full FIFO
  task automatic auto_max;
    feed_num = 1024;
    stall_en = 1'b1;
    wr(dtm_pkg::SEL_PRIMARY, 3'h0, dtm_pkg::MODE_AUTO, 10'h3FF);
    req();
    wait_items(1024);
    stall_en = 1'b0;
    quiet(1024);
    chk(rx_last, 32'h0000_03FF);
    chk(32'(done_cnt), 32'h1);
    chk({31'h0, busy_reg}, 32'h0);
    chk({31'h0, src_ready}, 32'h1);
    // One word waits in the FIFO so a wrongly restarted run would show
    feed_num = 1025;
    req();
    quiet(1024);
  endtask : auto_max

  task automatic basic_gated;
    feed_num = 1026;
    wr(dtm_pkg::SEL_PRIMARY, 3'h0, dtm_pkg::MODE_BASIC, 10'h001);
    req();
    wait_items(1025);
    quiet(1025);
    chk({22'h0, items_left_reg}, 32'h0);
    req();
    wait_items(1026);
    chk(rx_last, 32'h0000_0401);
  endtask : basic_gated

  task automatic ping_pong;
    feed_num = 1029;
    wr(dtm_pkg::SEL_PRIMARY, 3'h0, dtm_pkg::MODE_PING, 10'h000);
    wr(dtm_pkg::SEL_ALTERNATE, 3'h0, dtm_pkg::MODE_PING, 10'h000);
    req();
    wait_items(1027);
    quiet(1027);
    chk({31'h0, use_alt_reg}, 32'h1);
    // Refresh the primary as basic: one more cycle on it, then the end
    wr(dtm_pkg::SEL_PRIMARY, 3'h0, dtm_pkg::MODE_BASIC, 10'h000);
    req();
    wait_items(1028);
    quiet(1028);
    chk({31'h0, use_alt_reg}, 32'h0);
    chk({31'h0, busy_reg}, 32'h1);
    req();
    wait_items(1029);
    repeat (4) @(posedge sys_clk);
    chk({30'h0, busy_reg, use_alt_reg}, 32'h0);
    chk(rx_last, 32'h0000_0404);
    feed_num = 1030;
    req();
    quiet(1029);
  endtask : ping_pong

  task automatic mem_sg;
    int d0;
    d0 = done_cnt;
    feed_num = 1033;
    wr(dtm_pkg::SEL_TASK, 3'h0, dtm_pkg::MODE_ALT_MEM_SG, 10'h001);
    wr(dtm_pkg::SEL_TASK, 3'h1, dtm_pkg::MODE_ALT_MEM_SG, 10'h000);
    wr(dtm_pkg::SEL_PRIMARY, 3'h0, dtm_pkg::MODE_MEM_SG, 10'h001);
    req();
    wait_items(1032);
    quiet(1032);
    chk(rx_last, 32'h0000_0407);
    chk(32'(done_cnt - d0), 32'h2);
  endtask : mem_sg

  // Peripheral list: the starting request moves one item, then each
  // further item waits for a request of its own
  task automatic per_sg;
    feed_num = 1034;
    wr(dtm_pkg::SEL_TASK, 3'h0, dtm_pkg::MODE_ALT_PER_SG, 10'h001);
    wr(dtm_pkg::SEL_PRIMARY, 3'h0, dtm_pkg::MODE_PER_SG, 10'h000);
    req();
    wait_items(1033);
    quiet(1033);
    req();
    wait_items(1034);
    repeat (4) @(posedge sys_clk);
    chk(rx_last, 32'h0000_0409);
    chk({30'h0, busy_reg, use_alt_reg}, 32'h0);
    chk(32'(rx_bad), 32'h0);
  endtask : per_sg

  initial begin
    repeat (5) @(posedge sys_clk);
    chk({31'h0, src_ready}, 32'h0);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, src_ready}, 32'h1);
    fill_and_stop();
    auto_max();
    basic_gated();
    ping_pong();
    mem_sg();
    per_sg();
    tally_and_finish();
  end
endmodule : tb_top
